// [design/pic_cfg.svh]
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

// ----------------------------------------------------------------
// Device register byte addresses.
// ----------------------------------------------------------------
`define PIC_ADDR_PRIO_A 16'hFF20
`define PIC_ADDR_PRIO_B 16'hFF21
`define PIC_ADDR_EN_TIM 16'hFF22
`define PIC_ADDR_EN_IO 16'hFF23
`define PIC_ADDR_FLAG_TIM 16'hFF24
`define PIC_ADDR_FLAG_IO 16'hFF25

// ----------------------------------------------------------------
// Field positions inside the priority registers.
// ----------------------------------------------------------------
`define PIC_KEYGRP_PRIO_LSB 6
`define PIC_SERIAL_PRIO_LSB 4
`define PIC_STOPW_PRIO_LSB 2
`define PIC_CLKTIM_PRIO_LSB 0
`define PIC_PROGTIM_PRIO_LSB 2
`define PIC_SINGLEKEY_PRIO_LSB 0

// ----------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------
`define PIC_RST_BYTE 8'h00
`define PIC_RST_LEVEL 2'h0

// ----------------------------------------------------------------
// CPU end own registers.
// ----------------------------------------------------------------
`define PIC_ADDR_CPU_MASK 16'hFF30
`define PIC_ADDR_CPU_STAT 16'hFF31
`define PIC_ADDR_CPU_IMASK 16'hFF32
`define PIC_ADDR_CPU_VEC 16'hFF33
`define PIC_ADDR_CPU_CTRL 16'hFF34

// ----------------------------------------------------------------
// Vectors and timing.
// ----------------------------------------------------------------
`define PIC_VEC_NMI 8'h04
`define PIC_VEC_FIRST 8'h06
`define PIC_LEVEL_AFTER_NMI 2'h3
`define PIC_STACK_DEPTH 4
`define PIC_CLK_MHZ 100
`define PIC_NMI_SLEEP_GUARD_US 2000

`endif

// [design/pic_pkg.sv]
package pic_pkg;
  // Interrupt level of one source, 0 to 3.
  typedef logic [1:0] pic_level_t;
  // One bit per source, bit 14 first in vector order down to bit 0.
  typedef logic [14:0] pic_src_t;
  // Priority systems sharing one level field.
  typedef enum {PIC_SYS_PROGTIM, PIC_SYS_SINGLEKEY, PIC_SYS_KEYGRP, PIC_SYS_SERIAL,
                PIC_SYS_STOPW, PIC_SYS_CLKTIM} pic_sys_t;

  // Maps a source bit to the system whose level field it uses.
  function automatic pic_sys_t pic_sys_of(input int idx);
    pic_sys_t s;
    s = PIC_SYS_CLKTIM;
    if (idx >= 13) begin
      s = PIC_SYS_PROGTIM;
    end else if (idx == 12) begin
      s = PIC_SYS_SINGLEKEY;
    end else if (idx >= 10) begin
      s = PIC_SYS_KEYGRP;
    end else if (idx >= 7) begin
      s = PIC_SYS_SERIAL;
    end else if (idx >= 4) begin
      s = PIC_SYS_STOPW;
    end
    return s;
  endfunction
endpackage

// [design/pic_if.sv]
`timescale 1ns/10ps
// Link between the interrupt controller and the CPU core.
interface pic_if;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_rdata;
  logic irq_pend;
  logic [1:0] irq_level;
  logic [7:0] irq_vec;
  logic nmi_req;

  modport dev (input bus_addr, input bus_wdata, input bus_wr, input bus_rd, output bus_rdata,
               output irq_pend, output irq_level, output irq_vec, output nmi_req);
  modport cpu (output bus_addr, output bus_wdata, output bus_wr, output bus_rd, input bus_rdata,
               input irq_pend, input irq_level, input irq_vec, input nmi_req);
endinterface

// [design/pic_arbiter.sv]
`timescale 1ns/10ps
// Picks the winning pending source: highest level, then highest bit.
module pic_arbiter import pic_pkg::*; (
  // Requests.
  input wire pic_src_t pend,
  input wire logic [29:0] levels,
  // Winner.
  output logic win_valid,
  output pic_level_t win_level,
  output logic [3:0] win_idx
);
  // Ascending scan with >= lets the higher vector-order bit win ties.
  always_comb begin
    win_valid = 1'b0;
    win_level = 2'h0;
    win_idx = 4'h0;
    for (int i = 0; i < 15; i++) begin
      if (pend[i] && levels[2*i +: 2] != 2'h0 && levels[2*i +: 2] >= win_level) begin
        win_valid = 1'b1;
        win_level = levels[2*i +: 2];
        win_idx = 4'(i);
      end
    end
  end
endmodule // pic_arbiter

// [design/pic_device.sv]
// What this block does
// - Two-bit level fields, reset zero, read/write.
// - Key group and serial fields in FF20 upper.
// - Stopwatch and clock timer fields in FF20 lower.
// - Programmable timer field FF21 D3:D2, upper zero.
// - Single key field at FF21 D1:D0.
// - FF22 holds stopwatch and clock timer enables.
// - FF23 holds programmable, key, serial enables.
// - Enable one permits, zero blocks, reset zero.
// - FF24 holds stopwatch and clock timer flags.
// - FF25 holds programmable, key, serial flags.
// - Flags set on event, write one clears.
// - Uncleared flag re-raises after handler return.
// - Lowering mask with flag set re-raises.
// - Two-byte vectors, handlers start in common area.
// - No sleep for 2 ms after NMI.
// - Accept only above mask level; NMI always.
// - Equal levels resolved by fixed vector order.
`timescale 1ns/10ps
`include "pic_cfg.svh"

module pic_device import pic_pkg::*; (
  // System.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Link to the CPU core.
  pic_if.dev link,
  // Peripheral event pulses in vector order, bit 14 first.
  input wire pic_src_t src_event,
  // Watchdog event pulse.
  input wire logic wdt_event,
  // Summary interrupt.
  output logic irq_any
);

  // ----------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------
  logic [7:0] prio_a_reg;
  logic [3:0] prio_b_reg;
  logic [6:0] en_tim_reg;
  logic [7:0] en_io_reg;
  logic [6:0] flag_tim_reg;
  logic [7:0] flag_io_reg;
  logic [7:0] rdata_reg;
  logic irq_pend_reg;
  pic_level_t irq_level_reg;
  logic [7:0] irq_vec_reg;
  logic nmi_reg;
  logic irq_any_reg;

  // ----------------------------------------------------------------
  // Decode.
  // ----------------------------------------------------------------
  logic wr_prio_a;
  logic wr_prio_b;
  logic wr_en_tim;
  logic wr_en_io;
  logic wr_flag_tim;
  logic wr_flag_io;

  // Address decode of one-cycle write strobes.
  always_comb begin
    wr_prio_a = 1'b0;
    wr_prio_b = 1'b0;
    wr_en_tim = 1'b0;
    wr_en_io = 1'b0;
    wr_flag_tim = 1'b0;
    wr_flag_io = 1'b0;
    if (!link.bus_wr) begin
      wr_prio_a = 1'b0;
    end else if (link.bus_addr == `PIC_ADDR_PRIO_A) begin
      wr_prio_a = 1'b1;
    end else if (link.bus_addr == `PIC_ADDR_PRIO_B) begin
      wr_prio_b = 1'b1;
    end else if (link.bus_addr == `PIC_ADDR_EN_TIM) begin
      wr_en_tim = 1'b1;
    end else if (link.bus_addr == `PIC_ADDR_EN_IO) begin
      wr_en_io = 1'b1;
    end else if (link.bus_addr == `PIC_ADDR_FLAG_TIM) begin
      wr_flag_tim = 1'b1;
    end else if (link.bus_addr == `PIC_ADDR_FLAG_IO) begin
      wr_flag_io = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Priority registers.
  // ----------------------------------------------------------------
  // All level fields are plain read/write and clear to level 0.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prio_a_reg <= `PIC_RST_BYTE;
      prio_b_reg <= 4'h0;
    end else begin
      if (wr_prio_a) begin
        prio_a_reg <= link.bus_wdata;
      end
      if (wr_prio_b) begin
        prio_b_reg <= link.bus_wdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable registers.
  // ----------------------------------------------------------------
  // Enables are read/write and clear to blocked.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      en_tim_reg <= 7'h00;
      en_io_reg <= `PIC_RST_BYTE;
    end else begin
      if (wr_en_tim) begin
        en_tim_reg <= link.bus_wdata[6:0];
      end
      if (wr_en_io) begin
        en_io_reg <= link.bus_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Factor flags.
  // ----------------------------------------------------------------
  pic_src_t flags;
  pic_src_t clr_mask;
  pic_src_t flag_next;

  // Write one clears, write zero keeps; an event in the clearing cycle wins.
  always_comb begin
    flags = {flag_io_reg, flag_tim_reg};
    clr_mask = {wr_flag_io ? link.bus_wdata : 8'h00, wr_flag_tim ? link.bus_wdata[6:0] : 7'h00};
    flag_next = (flags & ~clr_mask) | src_event;
  end

  // Flags hold until software clears them, so a handler that returns
  // without clearing sees its request again.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flag_tim_reg <= 7'h00;
      flag_io_reg <= `PIC_RST_BYTE;
    end else begin
      flag_tim_reg <= flag_next[6:0];
      flag_io_reg <= flag_next[14:7];
    end
  end

  // ----------------------------------------------------------------
  // Read data.
  // ----------------------------------------------------------------
  // Read data stands in the cycle after the strobe; unused bits and
  // unmapped addresses read zero.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_reg <= `PIC_RST_BYTE;
    end else if (!link.bus_rd) begin
      rdata_reg <= 8'h00;
    end else if (link.bus_addr == `PIC_ADDR_PRIO_A) begin
      rdata_reg <= prio_a_reg;
    end else if (link.bus_addr == `PIC_ADDR_PRIO_B) begin
      rdata_reg <= {4'h0, prio_b_reg};
    end else if (link.bus_addr == `PIC_ADDR_EN_TIM) begin
      rdata_reg <= {1'b0, en_tim_reg};
    end else if (link.bus_addr == `PIC_ADDR_EN_IO) begin
      rdata_reg <= en_io_reg;
    end else if (link.bus_addr == `PIC_ADDR_FLAG_TIM) begin
      rdata_reg <= {1'b0, flag_tim_reg};
    end else if (link.bus_addr == `PIC_ADDR_FLAG_IO) begin
      rdata_reg <= flag_io_reg;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Per-source request and level.
  // ----------------------------------------------------------------
  pic_src_t enables;
  pic_src_t pend;
  logic [29:0] levels;
  logic [11:0] sys_levels;

  // System level fields, indexed by the system enumeration.
  assign sys_levels = {prio_a_reg[`PIC_CLKTIM_PRIO_LSB +: 2], prio_a_reg[`PIC_STOPW_PRIO_LSB +: 2],
                       prio_a_reg[`PIC_SERIAL_PRIO_LSB +: 2], prio_a_reg[`PIC_KEYGRP_PRIO_LSB +: 2],
                       prio_b_reg[`PIC_SINGLEKEY_PRIO_LSB +: 2], prio_b_reg[`PIC_PROGTIM_PRIO_LSB +: 2]};
  assign enables = {en_io_reg, en_tim_reg};

  // Each source requests only with flag and enable both set.
  for (genvar g = 0; g < 15; g++) begin : g_src
    assign pend[g] = flags[g] & enables[g];
    assign levels[2*g +: 2] = sys_levels[2*int'(pic_sys_of(g)) +: 2];
  end

  // ----------------------------------------------------------------
  // Arbitration toward the CPU.
  // ----------------------------------------------------------------
  logic win_valid;
  pic_level_t win_level;
  logic [3:0] win_idx;

  pic_arbiter u_arb (
    .pend(pend),
    .levels(levels),
    .win_valid(win_valid),
    .win_level(win_level),
    .win_idx(win_idx)
  );

  // Presents the winner with its two-byte vector address; the CPU
  // compares the level against its own mask.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_pend_reg <= 1'b0;
      irq_level_reg <= `PIC_RST_LEVEL;
      irq_vec_reg <= 8'h00;
    end else begin
      irq_pend_reg <= win_valid;
      irq_level_reg <= win_valid ? win_level : 2'h0;
      irq_vec_reg <= `PIC_VEC_FIRST + 8'({4'hE - win_idx, 1'b0});
    end
  end

  // Watchdog pulse, forwarded as a one-cycle non-maskable request.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      nmi_reg <= 1'b0;
    end else begin
      nmi_reg <= wdt_event;
    end
  end

  // Summary level, high while any enabled flag is set.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_any_reg <= 1'b0;
    end else begin
      irq_any_reg <= |pend;
    end
  end

  assign link.bus_rdata = rdata_reg;
  assign link.irq_pend = irq_pend_reg;
  assign link.irq_level = irq_level_reg;
  assign link.irq_vec = irq_vec_reg;
  assign link.nmi_req = nmi_reg;
  assign irq_any = irq_any_reg;

endmodule // pic_device

// [design/pic_cpu_end.sv]
`timescale 1ns/10ps
`include "pic_cfg.svh"

// CPU side: forwards software accesses, accepts requests against its mask.
module pic_cpu_end import pic_pkg::*; #(
  parameter int NMI_GUARD_CYCLES = `PIC_NMI_SLEEP_GUARD_US * `PIC_CLK_MHZ
) (
  // System.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Link to the interrupt controller.
  pic_if.cpu link,
  // Software port.
  input wire logic [15:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  // Events and sleep.
  output logic irq_out,
  input wire logic sleep_req,
  output logic sleep_grant
);

  // ----------------------------------------------------------------
  // Decode and forwarding.
  // ----------------------------------------------------------------
  logic is_dev;
  logic return_from_exception;
  logic wr_mask;
  assign is_dev = sw_addr >= `PIC_ADDR_PRIO_A && sw_addr <= `PIC_ADDR_FLAG_IO;
  assign link.bus_addr = sw_addr;
  assign link.bus_wdata = sw_wdata;
  assign link.bus_wr = sw_wr & is_dev;
  assign link.bus_rd = sw_rd & is_dev;
  assign return_from_exception = sw_wr && sw_addr == `PIC_ADDR_CPU_CTRL && sw_wdata[0];
  assign wr_mask = sw_wr && sw_addr == `PIC_ADDR_CPU_MASK;

  // ----------------------------------------------------------------
  // Acceptance.
  // ----------------------------------------------------------------
  pic_level_t mask_reg;
  pic_level_t stack_mem [`PIC_STACK_DEPTH];
  logic [2:0] sp_reg;
  logic [7:0] vec_reg;
  logic acc_irq;
  logic acc_any;
  // Only levels strictly above the mask pass; NMI always passes.
  assign acc_irq = link.irq_pend && link.irq_level > mask_reg && !return_from_exception;
  assign acc_any = link.nmi_req || acc_irq;

  // Accept raises the mask; return restores it, so a flag still set re-raises.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mask_reg <= `PIC_RST_LEVEL;
      sp_reg <= 3'h0;
      vec_reg <= 8'h00;
    end else if (acc_any) begin
      mask_reg <= link.nmi_req ? `PIC_LEVEL_AFTER_NMI : link.irq_level;
      vec_reg <= link.nmi_req ? `PIC_VEC_NMI : link.irq_vec;
      if (sp_reg != 3'(`PIC_STACK_DEPTH)) begin
        stack_mem[sp_reg[1:0]] <= mask_reg;
        sp_reg <= sp_reg + 3'h1;
      end
    end else if (return_from_exception && sp_reg != 3'h0) begin
      mask_reg <= stack_mem[sp_reg[1:0] - 2'h1];
      sp_reg <= sp_reg - 3'h1;
    end else if (wr_mask) begin
      mask_reg <= sw_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Event status and interrupt output.
  // ----------------------------------------------------------------
  logic [1:0] stat_reg;
  logic [1:0] imask_reg;
  logic irq_reg;
  logic [1:0] stat_clr;
  assign stat_clr = (sw_wr && sw_addr == `PIC_ADDR_CPU_STAT) ? sw_wdata[1:0] : 2'h0;

  // Bit 0 maskable accept, bit 1 NMI accept; set wins over clear.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stat_reg <= 2'h0;
      imask_reg <= 2'h0;
      irq_reg <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~stat_clr) | {link.nmi_req, acc_irq && !link.nmi_req};
      if (sw_wr && sw_addr == `PIC_ADDR_CPU_IMASK) begin
        imask_reg <= sw_wdata[1:0];
      end
      irq_reg <= |(stat_reg & imask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Sleep guard after NMI.
  // ----------------------------------------------------------------
  logic [17:0] guard_reg;
  logic grant_reg;
  // Sleep stays refused while the guard counts down.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      guard_reg <= 18'h00000;
      grant_reg <= 1'b0;
    end else begin
      if (link.nmi_req) begin
        guard_reg <= 18'(NMI_GUARD_CYCLES);
      end else if (guard_reg != 18'h00000) begin
        guard_reg <= guard_reg - 18'h00001;
      end
      grant_reg <= sleep_req && guard_reg == 18'h00000 && !link.nmi_req;
    end
  end

  // ----------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------
  logic [7:0] own_rdata_reg;
  logic sel_dev_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      own_rdata_reg <= 8'h00;
      sel_dev_reg <= 1'b0;
    end else begin
      sel_dev_reg <= sw_rd && is_dev;
      if (!sw_rd) begin
        own_rdata_reg <= 8'h00;
      end else if (sw_addr == `PIC_ADDR_CPU_MASK) begin
        own_rdata_reg <= {6'h00, mask_reg};
      end else if (sw_addr == `PIC_ADDR_CPU_STAT) begin
        own_rdata_reg <= {6'h00, stat_reg};
      end else if (sw_addr == `PIC_ADDR_CPU_IMASK) begin
        own_rdata_reg <= {6'h00, imask_reg};
      end else if (sw_addr == `PIC_ADDR_CPU_VEC) begin
        own_rdata_reg <= vec_reg;
      end else if (sw_addr == `PIC_ADDR_CPU_CTRL) begin
        own_rdata_reg <= {5'h00, sp_reg};
      end else begin
        own_rdata_reg <= 8'h00;
      end
    end
  end

  assign sw_rdata = sel_dev_reg ? link.bus_rdata : own_rdata_reg;
  assign irq_out = irq_reg;
  assign sleep_grant = grant_reg;

endmodule // pic_cpu_end

// [testbench/pic_link_sva.sv]
`timescale 1ns/10ps
`include "pic_cfg.svh"

// ----------------------------------------------------------------
// Link checker
// ----------------------------------------------------------------
// Watches the controller side of the link between the two ends.
module pic_link_sva (
  // System.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register path.
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  // Request path.
  input wire logic irq_pend,
  input wire logic [1:0] irq_level,
  input wire logic [7:0] irq_vec,
  input wire logic nmi_req
);
  // A write then an immediate read of one place returns the write data, unbuilt bits as zero.
  property wr_then_rd(logic [15:0] a, logic [7:0] keep);
    @(posedge clk_sys) disable iff (sys_rst)
      (bus_wr && bus_addr == a) ##1 (bus_rd && bus_addr == a) |=> bus_rdata == ($past(bus_wdata, 2) & keep);
  endproperty

  prio_a_rw_a:
    assert property (wr_then_rd(`PIC_ADDR_PRIO_A, 8'hFF)) else $error("Priority A readback wrong.");
  prio_b_rw_a:
    assert property (wr_then_rd(`PIC_ADDR_PRIO_B, 8'h0F)) else $error("Priority B readback wrong.");
  tim_en_rw_a:
    assert property (wr_then_rd(`PIC_ADDR_EN_TIM, 8'h7F)) else $error("Timer enable readback wrong.");
  io_en_rw_a:
    assert property (wr_then_rd(`PIC_ADDR_EN_IO, 8'hFF)) else $error("Io enable readback wrong.");
  tim_flag_top_a:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
      bus_rd && bus_addr == `PIC_ADDR_FLAG_TIM |=> !bus_rdata[7]) else $error("Timer flag top bit set.");
  rdata_idle_a:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
      !bus_rd |=> bus_rdata == 8'h00) else $error("Read data outside read slot.");
  vec_order_a:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
      irq_pend |-> irq_vec >= 8'h06 && irq_vec <= 8'h22 && !irq_vec[0]) else $error("Vector out of range.");
  reset_quiet_a:
    assert property (@(posedge clk_sys)
      $fell(sys_rst) |-> !irq_pend && !nmi_req && bus_rdata == 8'h00) else $error("Outputs busy after reset.");

  // Main scenarios.
  top_level_c: cover property (@(posedge clk_sys) irq_pend && irq_level == 2'h3);
  nmi_c: cover property (@(posedge clk_sys) nmi_req);
  flag_clr_c: cover property (@(posedge clk_sys) bus_wr && bus_addr == `PIC_ADDR_FLAG_IO);
endmodule // pic_link_sva

// [testbench/tb_peripheral_interrupt_control.sv]
`timescale 1ns/10ps
`include "pic_cfg.svh"

module tb_peripheral_interrupt_control import pic_pkg::*; ;
  localparam int GUARD = 20;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] sw_addr = 16'h0000;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  logic irq_out;
  logic irq_any;
  logic sleep_req = 1'b0;
  logic sleep_grant;
  logic wdt_event = 1'b0;
  pic_src_t src_event = '0;
  logic [7:0] rdv;
  int n_mismatch = 0;
  int tests_run = 0;

  // Free running system clock.
  always #5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Both ends joined by the link
  // ----------------------------------------------------------------
  pic_if pic_if_inst ();
  pic_device pic_device_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(pic_if_inst.dev),
    .src_event(src_event), .wdt_event(wdt_event), .irq_any(irq_any));
  pic_cpu_end #(.NMI_GUARD_CYCLES(GUARD)) pic_cpu_end_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .link(pic_if_inst.cpu), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .irq_out(irq_out), .sleep_req(sleep_req), .sleep_grant(sleep_grant));
  pic_link_sva pic_link_sva_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_addr(pic_if_inst.bus_addr),
    .bus_wdata(pic_if_inst.bus_wdata), .bus_wr(pic_if_inst.bus_wr), .bus_rd(pic_if_inst.bus_rd),
    .bus_rdata(pic_if_inst.bus_rdata), .irq_pend(pic_if_inst.irq_pend), .irq_level(pic_if_inst.irq_level),
    .irq_vec(pic_if_inst.irq_vec), .nmi_req(pic_if_inst.nmi_req));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s, got %h, expected %h", $time, what, got, exp);
    end
  endtask

  // One cycle write strobe; ends just after the edge that takes it.
  task wr(input logic [15:0] a, input logic [7:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
    #1;
  endtask

  // Read data stand in the cycle after the strobe only.
  task rdchk(input logic [15:0] a, input logic [7:0] exp, input string what);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1;
    rdv = sw_rdata;
    chk(rdv, exp, what);
  endtask

  task idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task do_reset();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    idle(1);
  endtask

  task pulse(input pic_src_t m, input logic w);
    src_event <= m;
    wdt_event <= w;
    @(posedge clk_sys);
    src_event <= '0;
    wdt_event <= 1'b0;
    #1;
  endtask

  // Waits a bounded time for the CPU end to report an accept; samples one
  // step after each edge so the registered output has settled.
  task wait_irq();
    int k;
    for (k = 0; k < 20 && irq_out !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    if (irq_out !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: no interrupt", $time);
      tally_and_finish();
    end
  endtask

  // Clears the accept status, then pops the mask.
  task ack_return();
    wr(`PIC_ADDR_CPU_STAT, 8'h03);
    wr(`PIC_ADDR_CPU_CTRL, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task s_regs();
    logic [7:0] keep [6];
    logic [15:0] a;
    keep = '{8'hFF, 8'h0F, 8'h7F, 8'hFF, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      a = 16'hFF20 + 16'(i);
      rdchk(a, 8'h00, "reset value");
      wr(a, 8'hFF);
      rdchk(a, keep[i], "ones readback");
      wr(a, 8'h5A);
      rdchk(a, 8'h5A & keep[i], "pattern readback");
    end
    wr(16'hFF40, 8'hFF);
    rdchk(16'hFF40, 8'h00, "unmapped read");
  endtask

  task s_flags();
    logic [15:0] a;
    logic [7:0] b;
    do_reset();
    for (int i = 0; i < 15; i++) begin
      a = (i < 7) ? `PIC_ADDR_FLAG_TIM : `PIC_ADDR_FLAG_IO;
      b = 8'h01 << ((i < 7) ? i : i - 7);
      pulse(pic_src_t'(1) << i, 1'b0);
      wr(a, 8'h00);
      rdchk(a, b, "flag kept by zero write");
      wr(a, b);
      rdchk(a, 8'h00, "flag cleared by one");
    end
  endtask

  task s_block();
    do_reset();
    wr(`PIC_ADDR_CPU_IMASK, 8'h03);
    wr(`PIC_ADDR_EN_TIM, 8'h01);
    pulse(15'h0002, 1'b0);
    idle(4);
    chk({7'h0, irq_any}, 8'h00, "disabled source quiet");
    pulse(15'h0001, 1'b0);
    idle(4);
    chk({7'h0, irq_any}, 8'h01, "enabled source shown");
    idle(6);
    rdchk(`PIC_ADDR_CPU_STAT, 8'h00, "level zero refused");
  endtask

  task s_accept();
    do_reset();
    wr(`PIC_ADDR_CPU_IMASK, 8'h01);
    wr(`PIC_ADDR_PRIO_A, 8'h03);
    wr(`PIC_ADDR_PRIO_B, 8'h04);
    wr(`PIC_ADDR_EN_TIM, 8'h01);
    wr(`PIC_ADDR_EN_IO, 8'h80);
    pulse(15'h4001, 1'b0);
    wait_irq();
    rdchk(`PIC_ADDR_CPU_VEC, 8'h22, "higher level wins");
    rdchk(`PIC_ADDR_CPU_MASK, 8'h03, "mask at level");
    rdchk(`PIC_ADDR_CPU_CTRL, 8'h01, "one level stacked");
    ack_return();
    wait_irq();
    rdchk(`PIC_ADDR_CPU_VEC, 8'h22, "uncleared flag again");
    wr(`PIC_ADDR_FLAG_TIM, 8'h01);
    ack_return();
    wait_irq();
    rdchk(`PIC_ADDR_CPU_VEC, 8'h06, "level one source");
    rdchk(`PIC_ADDR_CPU_MASK, 8'h01, "mask at level one");
    wr(`PIC_ADDR_CPU_STAT, 8'h03);
    wr(`PIC_ADDR_CPU_MASK, 8'h00);
    wait_irq();
    rdchk(`PIC_ADDR_CPU_VEC, 8'h06, "lowered mask again");
  endtask

  task s_order();
    do_reset();
    wr(`PIC_ADDR_CPU_IMASK, 8'h01);
    wr(`PIC_ADDR_PRIO_A, 8'hC0);
    wr(`PIC_ADDR_PRIO_B, 8'h0D);
    wr(`PIC_ADDR_EN_IO, 8'h70);
    pulse(15'h3800, 1'b0);
    wait_irq();
    rdchk(`PIC_ADDR_CPU_VEC, 8'h08, "equal level tie");
    wr(`PIC_ADDR_FLAG_IO, 8'h40);
    ack_return();
    wait_irq();
    rdchk(`PIC_ADDR_CPU_VEC, 8'h0C, "next in order");
    wr(`PIC_ADDR_FLAG_IO, 8'h10);
    ack_return();
    wait_irq();
    rdchk(`PIC_ADDR_CPU_VEC, 8'h0A, "single key at level one");
  endtask

  task s_nmi();
    int k;
    do_reset();
    sleep_req <= 1'b1;
    wr(`PIC_ADDR_CPU_IMASK, 8'h03);
    wr(`PIC_ADDR_PRIO_A, 8'h02);
    wr(`PIC_ADDR_EN_TIM, 8'h01);
    wr(`PIC_ADDR_CPU_MASK, 8'h03);
    pulse(15'h0001, 1'b0);
    idle(8);
    rdchk(`PIC_ADDR_CPU_STAT, 8'h00, "level two under mask");
    chk({7'h0, sleep_grant}, 8'h01, "sleep before watchdog");
    pulse(15'h0000, 1'b1);
    wait_irq();
    chk({7'h0, sleep_grant}, 8'h00, "sleep held off");
    rdchk(`PIC_ADDR_CPU_STAT, 8'h02, "watchdog taken");
    rdchk(`PIC_ADDR_CPU_VEC, `PIC_VEC_NMI, "watchdog vector");
    rdchk(`PIC_ADDR_CPU_MASK, 8'h03, "mask after watchdog");
    for (k = 0; k < 2 * GUARD && sleep_grant !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk({7'h0, sleep_grant}, 8'h01, "sleep after guard");
  endtask

  // Main sequence.
  initial begin
    do_reset();
    s_regs();
    s_flags();
    s_block();
    s_accept();
    s_order();
    s_nmi();
    tally_and_finish();
  end
endmodule // tb_peripheral_interrupt_control
